// ==== hdl/cbcd_regs.svh ====
`ifndef CBCD_REGS_SVH
`define CBCD_REGS_SVH

// ----------------------------------------------------------------------
// Command frame layout
// ----------------------------------------------------------------------
// Bits in one command frame and the last bit position of the frame.
`define CBCD_FRAME_BITS 8'd48
`define CBCD_FRAME_LAST 6'd47
// Number of leading frame bits covered by the checksum.
`define CBCD_CRC_SPAN 8'd40
// Checksum generator polynomial x^7 + x^3 + 1, leading term dropped.
`define CBCD_CRC_POLY 7'h09
`define CBCD_CRC_INIT 7'h00

// ----------------------------------------------------------------------
// Command indices
// ----------------------------------------------------------------------
`define CBCD_IDX_GO_IDLE 6'h00
`define CBCD_IDX_OP_COND 6'h01
`define CBCD_IDX_BCAST_ID 6'h02
`define CBCD_IDX_SET_ADDR 6'h03
`define CBCD_IDX_SELECT 6'h07
`define CBCD_IDX_READ_SPEC 6'h09
`define CBCD_IDX_READ_ID 6'h0A
`define CBCD_IDX_STATUS 6'h0D
`define CBCD_IDX_INACTIVE 6'h0F

// ----------------------------------------------------------------------
// Response layout
// ----------------------------------------------------------------------
`define CBCD_RESP_SHORT 8'd48
`define CBCD_RESP_LONG 8'd136
// Index field sent in long and operating-condition responses.
`define CBCD_RESP_ALL_ONES 6'h3F
`define CBCD_RESP_CRC_ONES 7'h7F
`define CBCD_RESP_CRC_LAST 8'd46
`define CBCD_RESP_END_POS 8'd47
// Address that no card may hold (the set-address command still stores it), and the address after reset.
`define CBCD_ADDR_NONE 16'h0000
`define CBCD_ADDR_RESET 16'h0001
// Current-state field of the status word.
`define CBCD_STAT_STATE_LSB 9
`define CBCD_STAT_STATE_MSB 12
// Power-up done flag of the operating-conditions word.
`define CBCD_OCR_DONE_BIT 31
// Response turnaround in clocks after a command.
`define CBCD_NCR_CYCLES 2

`endif

// ==== hdl/cbcd_pkg.sv ====
`include "cbcd_regs.svh"

package cbcd_pkg;

	// Card state, coded as in the status word's state field.
	typedef enum logic [3:0] {
		CBCD_ST_IDLE = 4'h0,
		CBCD_ST_READY = 4'h1,
		CBCD_ST_IDENT = 4'h2,
		CBCD_ST_STBY = 4'h3,
		CBCD_ST_TRAN = 4'h4,
		CBCD_ST_PRG = 4'h7,
		CBCD_ST_DIS = 4'h8,
		CBCD_ST_INA = 4'hF
	} cbcd_state_t;

	// Phase of the response transmitter.
	typedef enum logic [1:0] {
		CBCD_TX_IDLE = 2'b00,
		CBCD_TX_WAIT = 2'b01,
		CBCD_TX_SEND = 2'b10
	} cbcd_tx_t;

	// One checksum step for one serial bit, most significant bit first.
	function automatic logic [6:0] cbcd_crc7_step(input logic [6:0] crc,
		input logic bit_in);
		logic fb;
		fb = crc[6] ^ bit_in;
		cbcd_crc7_step = {crc[5:0], 1'b0} ^ (fb ? `CBCD_CRC_POLY : 7'h00);
	endfunction

endpackage

// ==== hdl/cbcd_frame_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Carries a received command frame from the receiver to the decoder.
interface cbcd_frame_if;
	logic valid; // One-cycle pulse: a whole frame was received.
	logic ok; // Framing and checksum were good.
	logic [5:0] index; // Command index.
	logic [31:0] arg; // Command argument.
	logic hold; // Decoder busy answering; receiver stays idle.

	modport rx (output valid, output ok, output index, output arg,
		input hold);
	modport dec (input valid, input ok, input index, input arg,
		output hold);
endinterface

`default_nettype wire

// ==== hdl/cbcd_cmd_rx.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cbcd_regs.svh"

module cbcd_cmd_rx
	import cbcd_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Serial command line as seen by the card.
	input wire logic cmd_in,
	// Frame towards the decoder.
	cbcd_frame_if.rx frm
);

	logic act_q, act_d; // A frame is being shifted in.
	logic [5:0] cnt_q, cnt_d; // Position of the next bit.
	logic [46:0] sh_q, sh_d; // Bits received so far.
	logic [6:0] crc_q, crc_d; // Running checksum.
	logic valid_q, valid_d;
	logic ok_q, ok_d;
	logic [5:0] idx_q, idx_d;
	logic [31:0] arg_q, arg_d;
	logic [47:0] frame; // Whole frame once the end bit arrives.

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// Shifts the line in first bit first, checks host bit, end bit and
	// checksum, and holds the last frame's fields for the decoder.
	always_comb
	begin
		act_d = act_q;
		cnt_d = cnt_q;
		sh_d = {sh_q[45:0], cmd_in};
		crc_d = crc_q;
		valid_d = 1'b0;
		ok_d = ok_q;
		idx_d = idx_q;
		arg_d = arg_q;
		frame = {sh_q, cmd_in};
		if (frm.hold)
		begin
			// Our own answer is on the line; it is not a command.
			act_d = 1'b0;
			cnt_d = 6'h00;
		end
		else if (!act_q)
		begin
			// A zero start bit opens a frame.
			if (!cmd_in)
			begin
				act_d = 1'b1;
				cnt_d = 6'h01;
				crc_d = cbcd_crc7_step(`CBCD_CRC_INIT, cmd_in);
			end
		end
		else
		begin
			if ({2'b00, cnt_q} < `CBCD_CRC_SPAN)
			begin
				crc_d = cbcd_crc7_step(crc_q, cmd_in);
			end
			cnt_d = cnt_q + 6'h01;
			if (cnt_q == `CBCD_FRAME_LAST)
			begin
				// Frame complete after 48 bits.
				act_d = 1'b0;
				valid_d = 1'b1;
				idx_d = frame[45:40];
				arg_d = frame[39:8];
				ok_d = frame[46] && frame[0] && (frame[7:1] == crc_q);
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Synchronous reset returns the receiver to hunting for a start bit.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			act_q <= 1'b0;
			cnt_q <= 6'h00;
			sh_q <= 47'h0;
			crc_q <= 7'h00;
			valid_q <= 1'b0;
			ok_q <= 1'b0;
			idx_q <= 6'h00;
			arg_q <= 32'h0;
		end
		else
		begin
			act_q <= act_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			crc_q <= crc_d;
			valid_q <= valid_d;
			ok_q <= ok_d;
			idx_q <= idx_d;
			arg_q <= arg_d;
		end
	end

	assign frm.valid = valid_q;
	assign frm.ok = ok_q;
	assign frm.index = idx_q;
	assign frm.arg = arg_q;

endmodule // cbcd_cmd_rx

`default_nettype wire

// ==== hdl/cbcd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cbcd_regs.svh"

module cbcd_decoder
	import cbcd_pkg::*;
#(
	parameter int NCR = `CBCD_NCR_CYCLES // Clocks from command to answer.
)
(
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Command line, split into sense, drive and enable.
	input wire logic CMD_IN,
	output logic CMD_OUT,
	output logic CMD_OE,
	// Card register contents supplied by the rest of the card.
	input wire logic [31:0] OCR_VALUE,
	input wire logic [127:0] IDENT_VALUE,
	input wire logic [127:0] SPEC_VALUE,
	input wire logic [31:0] STATUS_VALUE,
	input wire logic PROGRAM_BUSY,
	// Card state seen by the rest of the card.
	output cbcd_pkg::cbcd_state_t CARD_STATE,
	output logic [15:0] CARD_ADDR
);
	import cbcd_pkg::*;

	cbcd_frame_if frm (); // Received frames.

	// ------------------------------------------------------------------
	// Command receiver
	// ------------------------------------------------------------------
	cbcd_cmd_rx u_rx (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.cmd_in(CMD_IN),
		.frm(frm)
	);

	cbcd_state_t state_q, state_d; // Card state.
	logic [15:0] addr_q, addr_d; // relative_card_address.
	cbcd_tx_t ph_q, ph_d; // Transmitter phase.
	logic [7:0] wait_q, wait_d; // Turnaround countdown.
	logic [135:0] sh_q, sh_d; // Response bits, next bit on top.
	logic [7:0] len_q, len_d; // Response length in bits.
	logic [7:0] cnt_q, cnt_d; // Bits already sent.
	logic crc_en_q, crc_en_d; // Short response with computed checksum.
	logic [6:0] crc_q, crc_d; // Running response checksum.
	logic out_q, out_d;
	logic oe_q, oe_d;
	logic good; // A good frame has arrived.
	logic match; // Argument carries this card's address.
	logic addressed; // Card is in a state with an address.
	logic [31:0] status; // Status word with live state field.
	logic tx_bit; // Bit chosen for the line.

	// ------------------------------------------------------------------
	// Command decoder
	// ------------------------------------------------------------------
	// Moves the card state and queues the answer for each good frame, except in the inactive state, where frames are ignored.
	always_comb
	begin
		state_d = state_q;
		addr_d = addr_q;
		ph_d = ph_q;
		wait_d = wait_q;
		sh_d = sh_q;
		len_d = len_q;
		crc_en_d = crc_en_q;
		good = frm.valid && frm.ok;
		match = (frm.arg[31:16] == addr_q);
		addressed = (state_q == CBCD_ST_STBY) || (state_q == CBCD_ST_TRAN)
			|| (state_q == CBCD_ST_PRG) || (state_q == CBCD_ST_DIS);
		status = STATUS_VALUE;
		status[`CBCD_STAT_STATE_MSB:`CBCD_STAT_STATE_LSB] = state_q;
		if (good && (ph_q == CBCD_TX_IDLE) && (state_q != CBCD_ST_INA))
		begin
			unique case (frm.index)
				`CBCD_IDX_GO_IDLE:
				begin
					// Argument ignored; no answer is queued.
					state_d = CBCD_ST_IDLE;
					addr_d = `CBCD_ADDR_RESET;
				end
				`CBCD_IDX_OP_COND:
				begin
					// Idle cards answer with operating conditions.
					if (state_q == CBCD_ST_IDLE)
					begin
						sh_d = {2'b00, `CBCD_RESP_ALL_ONES, OCR_VALUE,
							`CBCD_RESP_CRC_ONES, 1'b1, 88'h0};
						len_d = `CBCD_RESP_SHORT;
						crc_en_d = 1'b0;
						ph_d = CBCD_TX_WAIT;
						if (OCR_VALUE[`CBCD_OCR_DONE_BIT])
						begin
							state_d = CBCD_ST_READY;
						end
					end
				end
				`CBCD_IDX_BCAST_ID:
				begin
					// Ready cards send their identity in a long answer.
					if (state_q == CBCD_ST_READY)
					begin
						sh_d = {2'b00, `CBCD_RESP_ALL_ONES, IDENT_VALUE[127:1],
							1'b1};
						len_d = `CBCD_RESP_LONG;
						crc_en_d = 1'b0;
						ph_d = CBCD_TX_WAIT;
						state_d = CBCD_ST_IDENT;
					end
				end
				`CBCD_IDX_SET_ADDR:
				begin
					// The identified card takes the host's address.
					if (state_q == CBCD_ST_IDENT)
					begin
						addr_d = frm.arg[31:16];
						sh_d = {2'b00, frm.index, status, 96'h0};
						len_d = `CBCD_RESP_SHORT;
						crc_en_d = 1'b1;
						ph_d = CBCD_TX_WAIT;
						state_d = CBCD_ST_STBY;
					end
				end
				`CBCD_IDX_SELECT:
				begin
					if (addressed && match && (frm.arg[31:16] != `CBCD_ADDR_NONE))
					begin
						// Selected: only this card answers.
						sh_d = {2'b00, frm.index, status, 96'h0};
						len_d = `CBCD_RESP_SHORT;
						crc_en_d = 1'b1;
						ph_d = CBCD_TX_WAIT;
						if (state_q == CBCD_ST_STBY)
						begin
							state_d = CBCD_ST_TRAN;
						end
						else if (state_q == CBCD_ST_DIS)
						begin
							state_d = CBCD_ST_PRG;
						end
					end
					else if (state_q == CBCD_ST_TRAN)
					begin
						// Any other address, zero included, deselects.
						state_d = CBCD_ST_STBY;
					end
					else if (state_q == CBCD_ST_PRG)
					begin
						state_d = CBCD_ST_DIS;
					end
				end
				`CBCD_IDX_READ_SPEC, `CBCD_IDX_READ_ID:
				begin
					// Register reads are served in stand-by only.
					if ((state_q == CBCD_ST_STBY) && match)
					begin
						sh_d = {2'b00, `CBCD_RESP_ALL_ONES,
							(frm.index == `CBCD_IDX_READ_SPEC) ?
							SPEC_VALUE[127:1] : IDENT_VALUE[127:1],
							1'b1};
						len_d = `CBCD_RESP_LONG;
						crc_en_d = 1'b0;
						ph_d = CBCD_TX_WAIT;
					end
				end
				`CBCD_IDX_STATUS:
				begin
					if (addressed && match)
					begin
						sh_d = {2'b00, frm.index, status, 96'h0};
						len_d = `CBCD_RESP_SHORT;
						crc_en_d = 1'b1;
						ph_d = CBCD_TX_WAIT;
					end
				end
				`CBCD_IDX_INACTIVE:
				begin
					if (addressed && match)
					begin
						state_d = CBCD_ST_INA;
					end
				end
				default:
				begin
					// Unsupported and reserved indices leave all as is.
					state_d = state_q;
				end
			endcase
			wait_d = 8'(NCR - 1);
		end
		else if (!good)
		begin
			// Between commands the store engine moves programming states.
			if ((state_q == CBCD_ST_TRAN) && PROGRAM_BUSY)
			begin
				state_d = CBCD_ST_PRG;
			end
			else if ((state_q == CBCD_ST_PRG) && !PROGRAM_BUSY)
			begin
				state_d = CBCD_ST_TRAN;
			end
			else if ((state_q == CBCD_ST_DIS) && !PROGRAM_BUSY)
			begin
				state_d = CBCD_ST_STBY;
			end
		end
		if (ph_q == CBCD_TX_WAIT)
		begin
			// Turnaround gap before the start bit.
			if (wait_q == 8'h00)
			begin
				ph_d = CBCD_TX_SEND;
			end
			else
			begin
				wait_d = wait_q - 8'h01;
			end
		end
		else if (ph_q == CBCD_TX_SEND)
		begin
			sh_d = {sh_q[134:0], 1'b0};
			if (cnt_q == len_q - 8'h01)
			begin
				ph_d = CBCD_TX_IDLE;
			end
		end
	end

	// ------------------------------------------------------------------
	// Response serialiser
	// ------------------------------------------------------------------
	// Sends the answer first bit first and, for short answers with crc_en_q set, swaps in
	// the computed checksum and end bit after the first forty bits.
	always_comb
	begin
		cnt_d = cnt_q;
		crc_d = crc_q;
		out_d = 1'b1;
		oe_d = 1'b0;
		tx_bit = sh_q[135];
		if (crc_en_q && (cnt_q >= `CBCD_CRC_SPAN)
			&& (cnt_q <= `CBCD_RESP_CRC_LAST))
		begin
			tx_bit = crc_q[6];
		end
		else if (crc_en_q && (cnt_q == `CBCD_RESP_END_POS))
		begin
			tx_bit = 1'b1;
		end
		if (ph_q == CBCD_TX_SEND)
		begin
			out_d = tx_bit;
			oe_d = 1'b1;
			cnt_d = cnt_q + 8'h01;
			if (cnt_q < `CBCD_CRC_SPAN)
			begin
				crc_d = cbcd_crc7_step(crc_q, tx_bit);
			end
			else
			begin
				crc_d = {crc_q[5:0], 1'b0};
			end
		end
		else
		begin
			cnt_d = 8'h00;
			crc_d = `CBCD_CRC_INIT;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Synchronous reset: idle card, default address, line released.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			state_q <= CBCD_ST_IDLE;
			addr_q <= `CBCD_ADDR_RESET;
			ph_q <= CBCD_TX_IDLE;
			wait_q <= 8'h00;
			sh_q <= 136'h0;
			len_q <= 8'h00;
			cnt_q <= 8'h00;
			crc_en_q <= 1'b0;
			crc_q <= 7'h00;
			out_q <= 1'b1;
			oe_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			addr_q <= addr_d;
			ph_q <= ph_d;
			wait_q <= wait_d;
			sh_q <= sh_d;
			len_q <= len_d;
			cnt_q <= cnt_d;
			crc_en_q <= crc_en_d;
			crc_q <= crc_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	// Receiver is held off while this card owns the line.
	assign frm.hold = (ph_q != CBCD_TX_IDLE) || oe_q;
	assign CMD_OUT = out_q;
	assign CMD_OE = oe_q;
	assign CARD_STATE = state_q;
	assign CARD_ADDR = addr_q;

endmodule // cbcd_decoder

`default_nettype wire

// ==== sim/cbcd_decoder_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

// Watches the answer framing and the card state at the decoder's ports.
module cbcd_decoder_properties
	import cbcd_pkg::*;
#(
	parameter int NCR = 2 // Turnaround clocks, as on the decoder.
)
(
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Card drive of the command line.
	input wire logic CMD_OUT,
	input wire logic CMD_OE,
	// Card state.
	input wire logic [3:0] CARD_STATE,
	input wire logic [15:0] CARD_ADDR
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	// Counts the edges for which the card has been driving the line.
	logic [7:0] run_q;
	logic [7:0] run_d;

	// Next count: grows while driving, clears when released.
	always_comb
	begin
		run_d = CMD_OE ? run_q + 8'h01 : 8'h00;
	end

	// Registers the count.
	always_ff @(posedge CLK_SYS)
	begin
		run_q <= RST_N ? run_d : 8'h00;
	end

	property p_idle_high;
		!CMD_OE |-> CMD_OUT;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("command drive not high while released");

	property p_start;
		$rose(CMD_OE) |-> !CMD_OUT ##1 !CMD_OUT;
	endproperty
	a_start: assert property (p_start)
		else $error("answer does not open with two zero bits");

	property p_len;
		$fell(CMD_OE) |-> (run_q == 8'h30 || run_q == 8'h88);
	endproperty
	a_len: assert property (p_len)
		else $error("answer length is neither short nor long");

	property p_end;
		$fell(CMD_OE) |-> $past(CMD_OUT);
	endproperty
	a_end: assert property (p_end)
		else $error("answer end bit not one");

	property p_idle_addr;
		CARD_STATE == CBCD_ST_IDLE |-> CARD_ADDR == 16'h0001;
	endproperty
	a_idle_addr: assert property (p_idle_addr)
		else $error("idle card holds an assigned address");

	property p_ina_hold;
		CARD_STATE == CBCD_ST_INA |=> CARD_STATE == CBCD_ST_INA;
	endproperty
	a_ina_hold: assert property (p_ina_hold)
		else $error("inactive card left inactive state");

	property p_ina_quiet;
		CARD_STATE == CBCD_ST_INA |-> !$rose(CMD_OE);
	endproperty
	a_ina_quiet: assert property (p_ina_quiet)
		else $error("inactive card answered");

	property p_addr_hold;
		CMD_OE ##1 CMD_OE |-> $stable(CARD_ADDR);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address changed during an answer");
endmodule // cbcd_decoder_properties

bind cbcd_decoder cbcd_decoder_properties #(.NCR(NCR)) u_props (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CMD_OUT(CMD_OUT), .CMD_OE(CMD_OE),
	.CARD_STATE(CARD_STATE), .CARD_ADDR(CARD_ADDR));

`default_nettype wire

// ==== sim/cbcd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Host end of the command line: sends frames and collects answers.
module cbcd_host_model
(
	// Clock and sensed line level.
	input wire logic clk,
	input wire logic line,
	// Host drive of the line; released means the pull-up wins.
	output logic drv_oe,
	output logic drv_bit
);
	initial
	begin
		drv_oe = 1'b0;
		drv_bit = 1'b1;
	end

	// Checksum over the low n bits of v, most significant first.
	function automatic logic [6:0] crc7(input logic [135:0] v, input int n);
		logic [6:0] c;
		logic f;
		c = 7'h00;
		for (int i = n - 1; i >= 0; i--)
		begin
			f = c[6] ^ v[i];
			c = {c[5:0], 1'b0} ^ (f ? 7'h09 : 7'h00);
		end
		return c;
	endfunction

	// Sends one frame, then waits a bounded time for len answer bits.
	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg,
		input logic bad, input int len, output logic got,
		output logic [135:0] r);
		logic [47:0] f;
		int w;
		f = {2'b01, idx, arg, 8'h01};
		f[7:1] = crc7({96'h0, f[47:8]}, 40) ^ {6'h00, bad};
		r = '0;
		w = 0;
		for (int i = 47; i >= 0; i--)
		begin
			drv_oe = 1'b1;
			drv_bit = f[i];
			@(posedge clk);
			#1;
		end
		drv_oe = 1'b0;
		while (line && w < 16)
		begin
			@(posedge clk);
			#1;
			w++;
		end
		got = !line;
		for (int i = 0; i < len && got; i++)
		begin
			r = {r[134:0], line};
			@(posedge clk);
			#1;
		end
	endtask
endmodule // cbcd_host_model

`default_nettype wire

// ==== sim/tb_card_basic_command_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_card_basic_command_decoder;
	import cbcd_pkg::*;
	localparam logic [31:0] OCR = 32'h80FF8000;
	localparam logic [127:0] ID_WORD = 128'h0123456789ABCDEFFEDCBA9876543211;
	localparam logic [127:0] SPEC_WORD = 128'h13579BDF2468ACE00F1E2D3C4B5A6978;
	localparam logic [31:0] STAT = 32'hA5A5A5A5;
	localparam logic [15:0] ADDR = 16'h1234;
	logic clk_sys, rst_n, prog_busy, h_oe, h_bit, cmd_out, cmd_oe;
	wire logic cmd_line;
	cbcd_state_t card_state;
	logic [15:0] card_addr;
	logic [135:0] r;
	logic got;
	int n_mismatch = 0;
	int checks_done = 0;

	// The line is pulled up whenever nobody drives it.
	assign cmd_line = cmd_oe ? cmd_out : (h_oe ? h_bit : 1'b1);
	always #12.5 clk_sys = ~clk_sys;

	cbcd_decoder dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .CMD_IN(cmd_line),
		.CMD_OUT(cmd_out), .CMD_OE(cmd_oe), .OCR_VALUE(OCR),
		.IDENT_VALUE(ID_WORD), .SPEC_VALUE(SPEC_WORD), .STATUS_VALUE(STAT),
		.PROGRAM_BUSY(prog_busy), .CARD_STATE(card_state),
		.CARD_ADDR(card_addr));
	cbcd_host_model host_u (.clk(clk_sys), .line(cmd_line), .drv_oe(h_oe),
		.drv_bit(h_bit));

	// Counts one comparison and reports a mismatch.
	task automatic check(input string what, input logic [135:0] e,
		input logic [135:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic test_done();
		if (n_mismatch == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Sends a command with junk low argument bits and checks answer presence.
	task automatic xfer(input logic [5:0] idx, input logic [15:0] a,
		input int len);
		host_u.cmd(idx, {a, 16'hFFFF}, 1'b0, len, got, r);
		check("answer present", len != 0, got);
	endtask

	// Status word as sent: state field holds the state before the command.
	function automatic logic [31:0] st(input logic [3:0] s);
		return {STAT[31:13], s, STAT[8:0]};
	endfunction

	// Short answer with its computed checksum.
	function automatic logic [135:0] r1(input logic [5:0] i, input logic [3:0] s);
		logic [39:0] h;
		h = {2'b00, i, st(s)};
		return {h, host_u.crc7({96'h0, h}, 40), 1'b1};
	endfunction

	// Waits n edges and settles after the last one.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic s_refuse();
		logic [5:0] bad [6] = '{6'h04, 6'h05, 6'h06, 6'h08, 6'h0B, 6'h0E};
		foreach (bad[i])
			xfer(bad[i], 16'h0001, 0);
		check("refused state", CBCD_ST_IDLE, card_state);
		host_u.cmd(6'h01, 32'h0, 1'b1, 0, got, r);
		check("bad checksum", 1'b0, got);
		xfer(6'h00, 16'h0000, 0);
		check("idle", CBCD_ST_IDLE, card_state);
	endtask

	task automatic s_up();
		xfer(6'h01, 16'h0000, 48);
		check("ocr", {2'b00, 6'h3F, OCR, 8'hFF}, r);
		xfer(6'h02, 16'h0000, 136);
		check("identity", {2'b00, 6'h3F, ID_WORD[127:1], 1'b1}, r);
		xfer(6'h03, ADDR, 48);
		check("addr answer", r1(6'h03, 4'h2), r);
		check("address", ADDR, card_addr);
	endtask

	task automatic s_read();
		xfer(6'h01, 16'h0000, 0);
		xfer(6'h09, 16'h5555, 0);
		xfer(6'h09, ADDR, 136);
		check("specific", {2'b00, 6'h3F, SPEC_WORD[127:1], 1'b1}, r);
		xfer(6'h0A, ADDR, 136);
		check("identity again", {2'b00, 6'h3F, ID_WORD[127:1], 1'b1}, r);
	endtask

	task automatic s_select();
		xfer(6'h07, ADDR, 48);
		check("select answer", r1(6'h07, 4'h3), r);
		xfer(6'h0D, ADDR, 48);
		check("status", r1(6'h0D, 4'h4), r);
		prog_busy = 1'b1;
		tick(3);
		check("programming", CBCD_ST_PRG, card_state);
		xfer(6'h07, 16'h0000, 0);
		check("disconnect", CBCD_ST_DIS, card_state);
		xfer(6'h07, ADDR, 48);
		check("reselect answer", r1(6'h07, 4'h8), r);
		check("reselect", CBCD_ST_PRG, card_state);
		xfer(6'h07, 16'h0000, 0);
		prog_busy = 1'b0;
		tick(3);
		check("standby", CBCD_ST_STBY, card_state);
		xfer(6'h07, ADDR, 48);
		xfer(6'h07, 16'h7777, 0);
		check("deselected", CBCD_ST_STBY, card_state);
	endtask

	task automatic s_inactive();
		xfer(6'h00, 16'hA5A5, 0);
		check("idle address", 16'h0001, card_addr);
		s_up();
		xfer(6'h0F, ADDR, 0);
		xfer(6'h00, 16'h0000, 0);
		check("inactive", CBCD_ST_INA, card_state);
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		check("reset state", CBCD_ST_IDLE, card_state);
	endtask

	initial
	begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		prog_busy = 1'b0;
		tick(2);
		rst_n = 1'b1;
		s_refuse();
		s_up();
		s_read();
		s_select();
		s_inactive();
		test_done();
	end

	// Cuts a hang short well after the expected run time.
	initial
	begin
		#(20000 * 25);
		n_mismatch++;
		test_done();
	end
endmodule // tb_card_basic_command_decoder

`default_nettype wire
